// >>> logic/ltd_defines.svh
/*
  Opcode patterns and reset values for the load/transfer decoder.
  Assumes 10-bit instruction words, bit 9 first as written in opcode tables.
*/
`ifndef LTD_DEFINES_SVH
`define LTD_DEFINES_SVH

// six-bit prefixes of the immediate-operand opcodes
`define OPH_ACC_LOAD_IMM     6'h23
`define OPH_AUX_LOAD_IMM     6'h20
`define OPH_MEM_IMM_ROW_INC  6'h29
`define OPH_COL_PTR_LOAD_IMM 6'h22
`define OPH_ROW_PTR_LOAD_IMM 6'h21
`define OPH_ACC_FROM_MR      6'h27
`define OPH_SWAP_MR_ACC      6'h2F
// eight-bit prefix of the bank pointer immediate load
`define OPB_BANK_PTR_LOAD_IMM 8'h3C
// full ten-bit opcodes
`define OP_ACC_FROM_BANK_PTR 10'h100
`define OP_BANK_PTR_FROM_ACC 10'h110
`define OP_SECOND_WORD       10'h000
`define OP_SWAP_COL          10'h001
`define OP_SWAP_ROW          10'h002
`define OP_SWAP_BOTH         10'h003
`define OP_ACC_FROM_AUX      10'h048
`define OP_AUX_FROM_ACC      10'h0C8
`define OP_ACC_FROM_ROW      10'h0AF
`define OP_ACC_FROM_SPX      10'h068
`define OP_ACC_FROM_SPY      10'h058
`define OP_COL_FROM_ACC      10'h0E8
`define OP_ROW_FROM_ACC      10'h0D8
`define OP_ROW_INC           10'h05C
`define OP_ROW_DEC           10'h0DF
`define OP_ROW_ADD_ACC       10'h054
`define OP_ROW_SUB_ACC       10'h0D4
// instruction word field positions
`define FLD_PFX6_HI 9
`define FLD_PFX6_LO 4
`define FLD_PFX8_LO 2
`define FLD_IMM_HI 3
`define FLD_IMM_LO 0
`define FLD_BANK_HI 1
// reset values
`define NIB_RESET  4'h0
`define BANK_RESET 2'h0

`endif

// >>> logic/ltd_pkg.sv
/*
  Types shared by the load/transfer decoder.
  Assumes ltd_defines.svh for the numeric constants.
*/
`default_nettype none
package ltd_pkg;
  typedef enum logic [0:0] {
    PH_FIRST = 1'b0,
    PH_SECOND = 1'b1
  } phase_t;

  // one RAM write toward the data memory
  typedef struct packed {
    logic we;
    logic [9:0] addr;
    logic [3:0] data;
  } mem_wr_t;

  // every register the decoder owns
  typedef struct packed {
    phase_t phase;
    logic [3:0] acc;
    logic [3:0] aux;
    logic [1:0] bank;
    logic [3:0] col;
    logic [3:0] row;
    logic [3:0] spare_col;
    logic [3:0] spare_row;
    logic status;
    logic second_skipped;
    mem_wr_t mem_wr;
    logic [15:0][3:0] mr;
  } ltd_state_t;
endpackage
`default_nettype wire

// >>> logic/load_transfer_instr_decode.sv
/*
  Load and transfer instruction decoder/executor of a 4-bit core.
  Assumes one instruction word per clock from the fetch path on the
  same clock; the data RAM takes the registered write port.
*/
// How it works
// - The core has 101 instructions in ten groups; this block runs the immediate, register transfer and RAM pointer groups.
// - Prefix 100011 copies the low four bits into the accumulator in one word and one cycle.
// - Prefix 100000 copies the low four bits into the auxiliary data register in one word and one cycle.
// - Prefix 101001 writes the immediate to the pointed RAM nibble, bumps the row pointer and reports not-zero, in one cycle.
// - The bank pointer immediate load takes the two lowest bits into the bank pointer in one cycle.
// - Prefix 100010 loads the immediate into the column pointer in one cycle.
// - Prefix 100001 loads the immediate into the row pointer in one cycle.
// - Bank pointer to accumulator takes two words and two cycles, the second an all-zero word that is consumed.
// - Accumulator to bank pointer takes two words and two cycles, the all-zero second word fetched and skipped.
// - The combined swap exchanges column and row pointers with their spare copies at once in one cycle.
// - Register-indirect RAM addresses are bank, column and row pointers joined into ten bits.
// - The four-bit operand of memory-register load and exchange picks one of sixteen memory-register slots.
`default_nettype none
`include "ltd_defines.svh"

module load_transfer_instr_decode (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // instruction words from the fetch path
  input wire logic instr_valid,
  input wire logic [9:0] instr_word,
  // data RAM write port
  output var ltd_pkg::mem_wr_t mem_wr,
  // architectural registers
  output logic [3:0] acc,
  output logic [3:0] aux,
  output logic [1:0] bank_ptr,
  output logic [3:0] col_ptr,
  output logic [3:0] row_ptr,
  output logic [3:0] spare_column_pointer,
  output logic [3:0] spare_row_pointer,
  // status and sequencing
  output logic status_flag,
  output logic second_word_skipped
);
  import ltd_pkg::*;

  ltd_state_t st_reg;
  ltd_state_t st_next;
  logic [5:0] hi6;
  logic [7:0] hi8;
  logic [3:0] imm4;
  logic [1:0] imm2;
  logic [4:0] sum5;
  logic [4:0] diff5;

  // opcode prefixes and operand fields cut from the word once
  assign hi6 = instr_word[`FLD_PFX6_HI:`FLD_PFX6_LO];
  assign hi8 = instr_word[`FLD_PFX6_HI:`FLD_PFX8_LO];
  assign imm4 = instr_word[`FLD_IMM_HI:`FLD_IMM_LO];
  assign imm2 = instr_word[`FLD_BANK_HI:`FLD_IMM_LO];
  assign sum5 = {1'b0, st_reg.row} + {1'b0, st_reg.acc};
  assign diff5 = {1'b0, st_reg.row} - {1'b0, st_reg.acc};

  // decode and execute one word per valid cycle
  always_comb begin
    st_next = st_reg;
    st_next.mem_wr.we = 1'b0;
    st_next.second_skipped = 1'b0;
    if (instr_valid) begin
      if (st_reg.phase == PH_SECOND) begin
        // padding word is consumed whatever it holds, the source owes zeros
        st_next.phase = PH_FIRST;
        st_next.second_skipped = 1'b1;
      end else begin
        // only three of the core's groups decode here
        case (hi6)
          `OPH_ACC_LOAD_IMM: st_next.acc = imm4;
          `OPH_AUX_LOAD_IMM: st_next.aux = imm4;
          `OPH_COL_PTR_LOAD_IMM: st_next.col = imm4;
          `OPH_ROW_PTR_LOAD_IMM: st_next.row = imm4;
          `OPH_MEM_IMM_ROW_INC: begin
            st_next.mem_wr.we = 1'b1;
            st_next.mem_wr.addr = {st_reg.bank, st_reg.col, st_reg.row};
            st_next.mem_wr.data = imm4;
            st_next.row = st_reg.row + 4'h1;
            st_next.status = (st_reg.row != 4'hF);
          end
          `OPH_ACC_FROM_MR: begin
            st_next.acc = st_reg.mr[imm4];
          end
          `OPH_SWAP_MR_ACC: begin
            st_next.acc = st_reg.mr[imm4];
            st_next.mr[imm4] = st_reg.acc;
          end
          default: begin
            if (hi8 == `OPB_BANK_PTR_LOAD_IMM) begin
              st_next.bank = imm2;
            end else begin
              case (instr_word)
                `OP_ACC_FROM_BANK_PTR: begin
                  st_next.acc = {2'h0, st_reg.bank};
                  st_next.phase = PH_SECOND;
                end
                `OP_BANK_PTR_FROM_ACC: begin
                  st_next.bank = st_reg.acc[`FLD_BANK_HI:`FLD_IMM_LO];
                  st_next.phase = PH_SECOND;
                end
                `OP_SWAP_COL: begin
                  st_next.col = st_reg.spare_col;
                  st_next.spare_col = st_reg.col;
                end
                `OP_SWAP_ROW: begin
                  st_next.row = st_reg.spare_row;
                  st_next.spare_row = st_reg.row;
                end
                `OP_SWAP_BOTH: begin
                  st_next.col = st_reg.spare_col;
                  st_next.spare_col = st_reg.col;
                  st_next.row = st_reg.spare_row;
                  st_next.spare_row = st_reg.row;
                end
                `OP_ACC_FROM_AUX: st_next.acc = st_reg.aux;
                `OP_AUX_FROM_ACC: st_next.aux = st_reg.acc;
                `OP_ACC_FROM_ROW: st_next.acc = st_reg.row;
                `OP_ACC_FROM_SPX: st_next.acc = st_reg.spare_col;
                `OP_ACC_FROM_SPY: st_next.acc = st_reg.spare_row;
                `OP_COL_FROM_ACC: st_next.col = st_reg.acc;
                `OP_ROW_FROM_ACC: st_next.row = st_reg.acc;
                `OP_ROW_INC: begin
                  st_next.row = st_reg.row + 4'h1;
                  st_next.status = (st_reg.row != 4'hF);
                end
                `OP_ROW_DEC: begin
                  st_next.row = st_reg.row - 4'h1;
                  st_next.status = (st_reg.row != 4'h0);
                end
                `OP_ROW_ADD_ACC: begin
                  st_next.row = sum5[3:0];
                  st_next.status = sum5[4];
                end
                `OP_ROW_SUB_ACC: begin
                  st_next.row = diff5[3:0];
                  st_next.status = ~diff5[4];
                end
                // other groups belong to neighbouring decoders
                default: st_next = st_next;
              endcase
            end
          end
        endcase
      end
    end
  end

  // every register resets to a constant
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.phase <= PH_FIRST;
      st_reg.bank <= `BANK_RESET;
      st_reg.acc <= `NIB_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs taken straight from the state flops
  assign mem_wr = st_reg.mem_wr;
  assign acc = st_reg.acc;
  assign aux = st_reg.aux;
  assign bank_ptr = st_reg.bank;
  assign col_ptr = st_reg.col;
  assign row_ptr = st_reg.row;
  assign spare_column_pointer = st_reg.spare_col;
  assign spare_row_pointer = st_reg.spare_row;
  assign status_flag = st_reg.status;
  assign second_word_skipped = st_reg.second_skipped;

  // checks on the executed results
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  logic first_ok;
  assign first_ok = instr_valid && (st_reg.phase == PH_FIRST);

  sequence s_two_word_start;
    first_ok && (instr_word == `OP_ACC_FROM_BANK_PTR ||
      instr_word == `OP_BANK_PTR_FROM_ACC);
  endsequence
  sequence s_pad_word;
    instr_valid && (st_reg.phase == PH_SECOND);
  endsequence

  property p_acc_imm;
    first_ok && hi6 == `OPH_ACC_LOAD_IMM |=> acc == $past(instr_word[3:0]);
  endproperty
  a_acc_imm: assert property (p_acc_imm) else $error("acc imm");
  property p_aux_imm;
    first_ok && hi6 == `OPH_AUX_LOAD_IMM |=>
      aux == $past(instr_word[3:0]) && acc == $past(acc);
  endproperty
  a_aux_imm: assert property (p_aux_imm) else $error("aux imm");
  property p_mem_imm;
    first_ok && hi6 == `OPH_MEM_IMM_ROW_INC |=> mem_wr.we &&
      mem_wr.data == $past(instr_word[3:0]) &&
      mem_wr.addr == {$past(bank_ptr), $past(col_ptr), $past(row_ptr)} &&
      row_ptr == $past(row_ptr) + 4'h1 && status_flag == (row_ptr != 4'h0);
  endproperty
  a_mem_imm: assert property (p_mem_imm) else $error("mem imm");
  property p_bank_imm;
    first_ok && instr_word[9:2] == `OPB_BANK_PTR_LOAD_IMM |=>
      bank_ptr == $past(instr_word[1:0]);
  endproperty
  a_bank_imm: assert property (p_bank_imm) else $error("bank imm");
  property p_col_imm;
    first_ok && hi6 == `OPH_COL_PTR_LOAD_IMM |=>
      col_ptr == $past(instr_word[3:0]);
  endproperty
  a_col_imm: assert property (p_col_imm) else $error("col imm");
  property p_row_imm;
    first_ok && hi6 == `OPH_ROW_PTR_LOAD_IMM |=>
      row_ptr == $past(instr_word[3:0]);
  endproperty
  a_row_imm: assert property (p_row_imm) else $error("row imm");
  property p_two_word;
    s_two_word_start |=> st_reg.phase == PH_SECOND;
  endproperty
  a_two_word: assert property (p_two_word) else $error("pad");
  // the padding word is swallowed and executes nothing
  property p_pad_word;
    s_pad_word |=> second_word_skipped && st_reg.phase == PH_FIRST &&
      $stable(acc) && $stable(bank_ptr) && $stable(row_ptr) && !mem_wr.we;
  endproperty
  a_pad_word: assert property (p_pad_word) else $error("pad word");
  property p_acc_from_bank;
    first_ok && instr_word == `OP_ACC_FROM_BANK_PTR |=>
      acc == {2'h0, $past(bank_ptr)};
  endproperty
  a_acc_from_bank: assert property (p_acc_from_bank)
    else $error("acc from bank");
  property p_bank_from_acc;
    first_ok && instr_word == `OP_BANK_PTR_FROM_ACC |=>
      bank_ptr == $past(acc[1:0]) ##1 bank_ptr == $past(bank_ptr);
  endproperty
  a_bank_from_acc: assert property (p_bank_from_acc)
    else $error("bank from acc");
  property p_swap_both;
    first_ok && instr_word == `OP_SWAP_BOTH |=>
      col_ptr == $past(spare_column_pointer) &&
      spare_column_pointer == $past(col_ptr) &&
      row_ptr == $past(spare_row_pointer) &&
      spare_row_pointer == $past(row_ptr);
  endproperty
  a_swap_both: assert property (p_swap_both) else $error("swap");
  property p_transfer_status;
    first_ok && instr_word == `OP_ACC_FROM_AUX |=>
      $stable(status_flag) && acc == $past(aux);
  endproperty
  a_transfer_status: assert property (p_transfer_status)
    else $error("transfer status");
endmodule
`default_nettype wire

// >>> bench/rom_fetch_model.sv
/*
  Behavioural program-ROM fetch path feeding the decoder one word a cycle.
  Assumes a push request set by the bench one cycle before the word shows.
*/
`default_nettype none
`include "ltd_defines.svh"
module rom_fetch_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // request from the bench
  input wire logic push,
  input wire logic [9:0] push_word,
  // instruction stream toward the decoder
  output logic instr_valid,
  output logic [9:0] instr_word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pad_due = 1'b0;
  logic p;
  logic r;
  logic [9:0] w;
  initial instr_valid = 1'b0;
  initial instr_word = 10'h000;
  // sample the request at the edge, drive 1 ns later to avoid races
  always @(posedge ref_clk) begin
    p = push;
    r = arst_n;
    w = push_word;
    #1;
    // reset is judged as sampled at the edge, not at the drive time
    if (!r) begin
      pad_due = 1'b0;
      instr_valid = 1'b0;
    end else if (pad_due) begin
      instr_valid = 1'b1;
      instr_word = 10'h000;
      pad_due = 1'b0;
    end else if (p) begin
      instr_valid = 1'b1;
      instr_word = w;
      // two-word opcodes get their all-zero second word on the next cycle unless reset is sampled at that edge
      pad_due = (w == `OP_ACC_FROM_BANK_PTR) ||
        (w == `OP_BANK_PTR_FROM_ACC);
    end else begin
      // an idle bus drops valid and inverts the held word each cycle
      instr_valid = 1'b0;
      instr_word = ~instr_word;
    end
  end
endmodule
`default_nettype wire

// >>> bench/load_transfer_instr_decode_bench.sv
/*
  Self-checking bench for the load/transfer decoder.
  Assumes the fetch model supplies words; inputs change 1 ns after edges.
*/
`default_nettype none
module load_transfer_instr_decode_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import ltd_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic push = 1'b0;
  logic [9:0] push_word = 10'h000;
  logic instr_valid;
  logic [9:0] instr_word;
  mem_wr_t mem_wr;
  logic [3:0] acc, aux, col_ptr, row_ptr;
  logic [3:0] spare_column_pointer, spare_row_pointer;
  logic [1:0] bank_ptr;
  logic status_flag, second_word_skipped;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;

  initial forever #4 ref_clk = ~ref_clk;

  rom_fetch_model u_rom_fetch_model (.ref_clk(ref_clk), .arst_n(arst_n),
    .push(push), .push_word(push_word), .instr_valid(instr_valid),
    .instr_word(instr_word));
  load_transfer_instr_decode u_load_transfer_instr_decode (
    .ref_clk(ref_clk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .mem_wr(mem_wr), .acc(acc), .aux(aux),
    .bank_ptr(bank_ptr), .col_ptr(col_ptr), .row_ptr(row_ptr),
    .spare_column_pointer(spare_column_pointer),
    .spare_row_pointer(spare_row_pointer), .status_flag(status_flag),
    .second_word_skipped(second_word_skipped));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // a hang is cut short well beyond the fewer than a hundred cycles needed
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [9:0] seen,
                       input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one word through the fetch model; returns when its results show
  task automatic run(input logic [9:0] w);
    push = 1'b1;
    push_word = w;
    @(posedge ref_clk);
    #1 push = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic t_imm();
    run(10'h239);
    check("acc", {6'h0, acc}, 10'h009);
    run(10'h205);
    check("aux", {6'h0, aux}, 10'h005);
    check("acc kept", {6'h0, acc}, 10'h009);
    run(10'h22A);
    check("col", {6'h0, col_ptr}, 10'h00A);
    run(10'h21F);
    check("row", {6'h0, row_ptr}, 10'h00F);
    run(10'h0F2);
    check("bank", {8'h0, bank_ptr}, 10'h002);
    $display("test immediates done");
  endtask
  task automatic t_mem();
    run(10'h296);
    check("we", {9'h0, mem_wr.we}, 10'h001);
    check("addr", mem_wr.addr, 10'h2AF);
    check("data", {6'h0, mem_wr.data}, 10'h006);
    check("row wrap", {6'h0, row_ptr}, 10'h000);
    check("nz", {9'h0, status_flag}, 10'h000);
    tick();
    check("we drop", {9'h0, mem_wr.we}, 10'h000);
    $display("test memory immediate done");
  endtask
  task automatic t_two();
    run(10'h110);
    check("bank from acc", {8'h0, bank_ptr}, 10'h001);
    tick();
    check("skip", {9'h0, second_word_skipped}, 10'h001);
    check("col kept", {6'h0, col_ptr}, 10'h00A);
    tick();
    check("skip drop", {9'h0, second_word_skipped}, 10'h000);
    run(10'h100);
    check("acc from bank", {6'h0, acc}, 10'h001);
    tick();
    check("skip", {9'h0, second_word_skipped}, 10'h001);
    $display("test two-word transfers done");
  endtask
  task automatic t_status();
    logic [9:0] ops [6] = '{10'h05C, 10'h0DF, 10'h0DF, 10'h054, 10'h0D4,
                            10'h0DF};
    logic [9:0] exp [6] = '{10'h011, 10'h010, 10'h00F, 10'h010, 10'h00F,
                            10'h01E};
    // row starts at 0 and acc holds 1: wrap, borrow and carry all hit
    for (int i = 0; i < 6; i++) begin
      run(ops[i]);
      check("row st", {5'h0, status_flag, row_ptr}, exp[i]);
    end
    $display("test row arithmetic done");
  endtask
  task automatic t_swap();
    run(10'h213);
    check("status kept", {9'h0, status_flag}, 10'h001);
    run(10'h003);
    check("col", {6'h0, col_ptr}, 10'h000);
    check("row", {6'h0, row_ptr}, 10'h000);
    check("spare col", {6'h0, spare_column_pointer}, 10'h00A);
    check("spare row", {6'h0, spare_row_pointer}, 10'h003);
    check("status kept", {9'h0, status_flag}, 10'h001);
    $display("test swap done");
  endtask
  task automatic t_mr();
    run(10'h2F3);
    check("xchg", {6'h0, acc}, 10'h000);
    run(10'h239);
    run(10'h273);
    check("slot 3", {6'h0, acc}, 10'h001);
    run(10'h274);
    check("slot 4", {6'h0, acc}, 10'h000);
    $display("test memory registers done");
  endtask
  // every single-word transfer and an opcode of another group
  task automatic t_xfer();
    run(10'h058);
    check("acc from spr", {6'h0, acc}, 10'h003);
    run(10'h068);
    check("acc from spc", {6'h0, acc}, 10'h00A);
    run(10'h001);
    check("col swap", {6'h0, col_ptr}, 10'h00A);
    check("spc swap", {6'h0, spare_column_pointer}, 10'h000);
    run(10'h002);
    check("row swap", {6'h0, row_ptr}, 10'h003);
    check("spr swap", {6'h0, spare_row_pointer}, 10'h000);
    run(10'h0AF);
    check("acc from row", {6'h0, acc}, 10'h003);
    run(10'h237);
    run(10'h0C8);
    check("aux from acc", {6'h0, aux}, 10'h007);
    run(10'h0E8);
    check("col from acc", {6'h0, col_ptr}, 10'h007);
    run(10'h0D8);
    check("row from acc", {6'h0, row_ptr}, 10'h007);
    run(10'h202);
    run(10'h048);
    check("acc from aux", {6'h0, acc}, 10'h002);
    // a word of another group must leave every register alone
    run(10'h3FF);
    check("foreign acc", {6'h0, acc}, 10'h002);
    check("foreign row", {6'h0, row_ptr}, 10'h007);
    check("status kept", {9'h0, status_flag}, 10'h001);
    $display("test register transfers done");
  endtask
  // one edge later every register output and the write enable must read zero
  task automatic t_reset_clear();
    tick();
    check("acc clear", {6'h0, acc}, 10'h000);
    check("aux clear", {6'h0, aux}, 10'h000);
    check("bank clear", {8'h0, bank_ptr}, 10'h000);
    check("col clear", {6'h0, col_ptr}, 10'h000);
    check("row clear", {6'h0, row_ptr}, 10'h000);
    check("spc clear", {6'h0, spare_column_pointer}, 10'h000);
    check("spr clear", {6'h0, spare_row_pointer}, 10'h000);
    check("st clear", {9'h0, status_flag}, 10'h000);
    check("skip clear", {9'h0, second_word_skipped}, 10'h000);
    check("we clear", {9'h0, mem_wr.we}, 10'h000);
    $display("test reset clear done");
  endtask
  // a reset in mid-run clears state and the core runs on afterwards
  task automatic t_mid_reset();
    arst_n = 1'b0;
    t_reset_clear();
    arst_n = 1'b1;
    t_reset_clear();
    run(10'h239);
    check("acc after reset", {6'h0, acc}, 10'h009);
    $display("test mid-run reset done");
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    t_reset_clear();
    t_imm();
    t_mem();
    t_two();
    t_status();
    t_swap();
    t_mr();
    t_xfer();
    t_mid_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
